// file: hdl/svs_pkg.sv
// Constants and types of the supervisor.
// Assumes a single 200 MHz clock domain.
package svs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_FREQ_MHZ = 200;
    localparam int unsigned DEG_TIME_NS = 8000;
    localparam int unsigned DEG_CYC = (DEG_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int unsigned IO_STG_TIME_US = 4000;
    localparam int unsigned IO_STG_CYC = IO_STG_TIME_US * CLK_FREQ_MHZ;
    localparam int unsigned RAIL_STG_TIME_US = 3000;
    localparam int unsigned RAIL_STG_CYC = RAIL_STG_TIME_US * CLK_FREQ_MHZ;
    localparam int unsigned DEG_W = 11;
    localparam int unsigned STG_W = 20;

    ////////////////////////////////////////////////////////////////////////
    // Rails
    localparam int unsigned NUM_RAILS = 5;
    localparam int unsigned NUM_EXT = 2;
    localparam int unsigned RAIL_BUCK_ONE = 0;
    localparam int unsigned RAIL_BUCK_TWO = 1;
    localparam int unsigned RAIL_BOOST = 2;
    localparam int unsigned RAIL_EXT_ONE = 3;
    localparam int unsigned RAIL_EXT_TWO = 4;
    localparam int unsigned CHAN_IO = 5;
    localparam int unsigned NUM_CHAN = 6;

    ////////////////////////////////////////////////////////////////////////
    // Status flag vector layout
    localparam int unsigned FLAG_W = 21;
    localparam int unsigned FLAG_IO_SUPPLY_LOW = 0;
    localparam int unsigned FLAG_BATTERY_LOW = 1;
    localparam int unsigned FLAG_REF_WARNING_ONE = 2;
    localparam int unsigned FLAG_REF_WARNING_TWO = 3;
    localparam int unsigned FLAG_REF_FAULT_ONE = 4;
    localparam int unsigned FLAG_REF_FAULT_TWO = 5;
    localparam int unsigned FLAG_RAIL_OV_LSB = 6;
    localparam int unsigned FLAG_RAIL_UV_LSB = 11;
    localparam int unsigned FLAG_RAIL_STG_LSB = 16;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic RESET_DRIVE_RST = 1'b1;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 21'h000000;
    localparam logic [NUM_EXT-1:0] EXT_EN_RST = 2'h0;

    typedef enum {SVS_RUN, SVS_FAULT} svs_mode_t;

endpackage

// file: hdl/svs_chan_if.sv
// Connection between the supervisor core and one monitor channel.
// Assumes comparator levels are already synchronised to the clock.
`timescale 1ns/1ps
interface svs_chan_if;
    logic en;
    logic ov;
    logic uv;
    logic duv;
    logic ov_det;
    logic uv_det;
    logic stg_det;

    modport mon (input en, input ov, input uv, input duv, output ov_det, output uv_det, output stg_det);
    modport ctl (output en, output ov, output uv, output duv, input ov_det, input uv_det, input stg_det);
endinterface

// file: hdl/svs_sync.sv
// Two-flop synchroniser for a bus of independent levels.
// Assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/1ps
module svs_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule

// file: hdl/svs_mon_chan.sv
// One monitor channel: deglitch and short-to-ground timers.
// Assumes synchronised comparator levels on the channel interface.
`timescale 1ns/1ps
module svs_mon_chan
    import svs_pkg::*;
#(
    parameter int unsigned STG_CYC = RAIL_STG_CYC,
    parameter bit HAS_DUV = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Channel
    svs_chan_if.mon ch
);
    localparam logic [DEG_W-1:0] DEG_LIM = DEG_W'(DEG_CYC);
    localparam logic [STG_W-1:0] STG_LIM = STG_W'(STG_CYC);

    logic [DEG_W-1:0] ov_cnt_ff;
    logic [DEG_W-1:0] uv_cnt_ff;
    logic [DEG_W-1:0] duv_cnt_ff;
    logic [STG_W-1:0] stg_cnt_ff;

    ////////////////////////////////////////////////////////////////////////
    // deglitch and short-to-ground timers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ov_cnt_ff <= '0;
        end else if (!ch.en || !ch.ov) begin
            ov_cnt_ff <= '0;
        end else if (ov_cnt_ff != DEG_LIM) begin
            ov_cnt_ff <= ov_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            uv_cnt_ff <= '0;
        end else if (!ch.en || !ch.uv) begin
            uv_cnt_ff <= '0;
        end else if (uv_cnt_ff != DEG_LIM) begin
            uv_cnt_ff <= uv_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            duv_cnt_ff <= '0;
        end else if (!HAS_DUV || !ch.en || !ch.duv) begin
            duv_cnt_ff <= '0;
        end else if (duv_cnt_ff != DEG_LIM) begin
            duv_cnt_ff <= duv_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stg_cnt_ff <= '0;
        end else if (!ch.en || !ch.uv) begin
            stg_cnt_ff <= '0;
        end else if (stg_cnt_ff != STG_LIM) begin
            stg_cnt_ff <= stg_cnt_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Detection levels, held while the excursion lasts
    assign ch.ov_det = (ov_cnt_ff == DEG_LIM);
    assign ch.uv_det = (uv_cnt_ff == DEG_LIM);
    assign ch.stg_det = (stg_cnt_ff == STG_LIM) || (HAS_DUV && (duv_cnt_ff == DEG_LIM));
endmodule

// file: hdl/svs_supervisor.sv
// Event logic of a multi-rail supply supervisor:
// supply, rail and reference monitors.
// Assumes raw comparator levels from the analog front end (asynchronous)
// and rail enable requests and flag clears from logic on the same clock.
//
// Overview of operation
// - Io supply over- or undervoltage drives the reset output low.
// - Without a reset event the reset output is released to the pull-up.
// - Io supply below undervoltage for over 4.0 ms raises short-to-ground.
// - Io supply short-to-ground requests hard reset and sets the io low flag.
// - Battery comparator below threshold sets the battery low flag.
// - Converter excursions shorter than deglitch time ignored, longer ones give events.
// - Converter undervoltage beyond 3.0 ms adds a short-to-ground event.
// - First two buck nodes: deep undervoltage past deglitch gives short-to-ground.
// - Monitoring of a rail runs only while that rail is enabled.
// - External rails use same deglitch and short-to-ground timing.
// - External rail overvoltage or short-to-ground turns its enable off.
// - Reference difference warning raises interrupt and sets matching warning flag.
// - Reference difference fault shuts down, enters fault, sets matching fault flag.
`timescale 1ns/1ps
module svs_supervisor
    import svs_pkg::*;
#(
    parameter int unsigned IO_STG_CYCLES = IO_STG_CYC,
    parameter int unsigned RAIL_STG_CYCLES = RAIL_STG_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Io supply and battery comparators
    input wire logic IO_SUPPLY_OV,
    input wire logic IO_SUPPLY_UV,
    input wire logic BATTERY_UV,
    // Rail comparators
    input wire logic [svs_pkg::NUM_RAILS-1:0] RAIL_OV,
    input wire logic [svs_pkg::NUM_RAILS-1:0] RAIL_UV,
    input wire logic [1:0] BUCK_DEEP_UV,
    // Reference difference comparators
    input wire logic [1:0] REF_WARN_CAUSE,
    input wire logic [1:0] REF_FAULT_CAUSE,
    // Rail enables
    input wire logic [svs_pkg::NUM_RAILS-1:0] RAIL_EN_REQ,
    output logic [svs_pkg::NUM_EXT-1:0] EXT_RAIL_EN,
    output logic RAIL_SHUTDOWN,
    // Reset towards the microcontroller
    output logic RESET_OUT_N_O,
    output logic RESET_OUT_N_OE,
    output logic HARD_RESET_REQ,
    // Device state and interrupt
    output logic FAULT_STATE,
    output logic REF_WARN_IRQ,
    // Events
    output logic IO_SUPPLY_STG_EVT,
    output logic [svs_pkg::NUM_RAILS-1:0] RAIL_OV_EVT,
    output logic [svs_pkg::NUM_RAILS-1:0] RAIL_UV_EVT,
    output logic [svs_pkg::NUM_RAILS-1:0] RAIL_STG_EVT,
    // Status flags
    input wire logic [svs_pkg::FLAG_W-1:0] FLAGS_CLR,
    output logic [svs_pkg::FLAG_W-1:0] FLAGS
);
    import svs_pkg::*;

    localparam int unsigned SYNC_W = 3 + 2 * NUM_RAILS + 6;

    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_in;
    logic io_ov_s;
    logic io_uv_s;
    logic bat_uv_s;
    logic [NUM_RAILS-1:0] rail_ov_s;
    logic [NUM_RAILS-1:0] rail_uv_s;
    logic [1:0] duv_s;
    logic [1:0] warn_s;
    logic [1:0] fault_s;

    svs_chan_if ch [NUM_CHAN] ();

    logic [NUM_CHAN-1:0] ch_en;
    logic [NUM_CHAN-1:0] ov_det;
    logic [NUM_CHAN-1:0] uv_det;
    logic [NUM_CHAN-1:0] stg_det;

    svs_mode_t mode_ff;
    logic [NUM_EXT-1:0] ext_en_ff;
    logic [NUM_EXT-1:0] ext_off_ff;
    logic [NUM_EXT-1:0] ext_trip;
    logic [NUM_EXT-1:0] nxt_ext_off;
    logic reset_drive_ff;
    logic io_stg_ff;
    logic hard_req_ff;
    logic [1:0] warn_prev_ff;
    logic warn_irq_ff;
    logic [NUM_RAILS-1:0] ov_evt_ff;
    logic [NUM_RAILS-1:0] uv_evt_ff;
    logic [NUM_RAILS-1:0] stg_evt_ff;
    logic [FLAG_W-1:0] flags_ff;
    logic [FLAG_W-1:0] flag_set;
    logic fault_hit;

    ////////////////////////////////////////////////////////////////////////
    // Comparator synchronisers
    assign raw_in = {REF_FAULT_CAUSE, REF_WARN_CAUSE, BUCK_DEEP_UV, RAIL_UV, RAIL_OV,
                     BATTERY_UV, IO_SUPPLY_UV, IO_SUPPLY_OV};

    svs_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(CLK),
        .rst(RESET),
        .d(raw_in),
        .q(sync_in)
    );

    assign io_ov_s = sync_in[0];
    assign io_uv_s = sync_in[1];
    assign bat_uv_s = sync_in[2];
    assign rail_ov_s = sync_in[3 +: NUM_RAILS];
    assign rail_uv_s = sync_in[3 + NUM_RAILS +: NUM_RAILS];
    assign duv_s = sync_in[3 + 2 * NUM_RAILS +: 2];
    assign warn_s = sync_in[5 + 2 * NUM_RAILS +: 2];
    assign fault_s = sync_in[7 + 2 * NUM_RAILS +: 2];

    ////////////////////////////////////////////////////////////////////////
    // Monitor enables
    // monitoring follows rail enable
    always_comb begin
        ch_en = '0;
        ch_en[RAIL_BUCK_ONE] = RAIL_EN_REQ[RAIL_BUCK_ONE] && (mode_ff == SVS_RUN);
        ch_en[RAIL_BUCK_TWO] = RAIL_EN_REQ[RAIL_BUCK_TWO] && (mode_ff == SVS_RUN);
        ch_en[RAIL_BOOST] = RAIL_EN_REQ[RAIL_BOOST] && (mode_ff == SVS_RUN);
        ch_en[RAIL_EXT_ONE] = ext_en_ff[0];
        ch_en[RAIL_EXT_TWO] = ext_en_ff[1];
        ch_en[CHAN_IO] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Monitor channels
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
            if (gi == CHAN_IO) begin : g_io
                assign ch[gi].ov = io_ov_s;
                assign ch[gi].uv = io_uv_s;
                assign ch[gi].duv = 1'b0;
            end else begin : g_rail
                assign ch[gi].ov = rail_ov_s[gi];
                assign ch[gi].uv = rail_uv_s[gi];
                assign ch[gi].duv = (gi < 2) ? duv_s[gi] : 1'b0;
            end
            assign ch[gi].en = ch_en[gi];
            assign ov_det[gi] = ch[gi].ov_det;
            assign uv_det[gi] = ch[gi].uv_det;
            assign stg_det[gi] = ch[gi].stg_det;

            // io supply uses its own long timer
            svs_mon_chan #(
                .STG_CYC((gi == CHAN_IO) ? IO_STG_CYCLES : RAIL_STG_CYCLES),
                .HAS_DUV(gi < 2)
            ) u_chan (
                .clk(CLK),
                .rst(RESET),
                .ch(ch[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Device mode
    assign fault_hit = |fault_s;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mode_ff <= SVS_RUN;
        end else begin
            case (mode_ff)
                SVS_RUN: begin
                    if (fault_hit) begin
                        mode_ff <= SVS_FAULT;
                    end
                end
                SVS_FAULT: begin
                    mode_ff <= SVS_FAULT;
                end
                default: begin
                    mode_ff <= SVS_FAULT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External rail enables
    assign ext_trip = ov_det[RAIL_EXT_ONE +: NUM_EXT] | stg_det[RAIL_EXT_ONE +: NUM_EXT];

    // Trip latch clears only when the request is withdrawn; a trip wins
    always_comb begin
        nxt_ext_off = (ext_off_ff & RAIL_EN_REQ[RAIL_EXT_ONE +: NUM_EXT]) | ext_trip;
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ext_off_ff <= EXT_EN_RST;
        end else begin
            ext_off_ff <= nxt_ext_off;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ext_en_ff <= EXT_EN_RST;
        end else if (fault_hit || mode_ff == SVS_FAULT) begin
            ext_en_ff <= '0;
        end else begin
            ext_en_ff <= RAIL_EN_REQ[RAIL_EXT_ONE +: NUM_EXT] & ~nxt_ext_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset output and hard reset
    // io short-to-ground requests hard reset
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            io_stg_ff <= 1'b0;
            hard_req_ff <= 1'b0;
        end else begin
            io_stg_ff <= stg_det[CHAN_IO];
            hard_req_ff <= stg_det[CHAN_IO] && !io_stg_ff;
        end
    end

    // io over- or undervoltage pulls reset low
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            reset_drive_ff <= RESET_DRIVE_RST;
        end else begin
            reset_drive_ff <= ov_det[CHAN_IO] || uv_det[CHAN_IO] || stg_det[CHAN_IO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference warning interrupt
    // interrupt on new warning cause
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            warn_prev_ff <= 2'h0;
            warn_irq_ff <= 1'b0;
        end else begin
            warn_prev_ff <= warn_s;
            warn_irq_ff <= |(warn_s & ~warn_prev_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered rail events
    // events only after deglitch
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ov_evt_ff <= '0;
            uv_evt_ff <= '0;
            stg_evt_ff <= '0;
        end else begin
            ov_evt_ff <= ov_det[NUM_RAILS-1:0];
            uv_evt_ff <= uv_det[NUM_RAILS-1:0];
            stg_evt_ff <= stg_det[NUM_RAILS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags
    always_comb begin
        flag_set = '0;
        // io short-to-ground sets io low flag
        flag_set[FLAG_IO_SUPPLY_LOW] = stg_det[CHAN_IO];
        flag_set[FLAG_BATTERY_LOW] = bat_uv_s;
        flag_set[FLAG_REF_WARNING_ONE] = warn_s[0];
        flag_set[FLAG_REF_WARNING_TWO] = warn_s[1];
        flag_set[FLAG_REF_FAULT_ONE] = fault_s[0];
        flag_set[FLAG_REF_FAULT_TWO] = fault_s[1];
        flag_set[FLAG_RAIL_OV_LSB +: NUM_RAILS] = ov_det[NUM_RAILS-1:0];
        flag_set[FLAG_RAIL_UV_LSB +: NUM_RAILS] = uv_det[NUM_RAILS-1:0];
        flag_set[FLAG_RAIL_STG_LSB +: NUM_RAILS] = stg_det[NUM_RAILS-1:0];
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            flags_ff <= FLAGS_RST;
        end else begin
            flags_ff <= (flags_ff & ~FLAGS_CLR) | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign EXT_RAIL_EN = ext_en_ff;
    assign RAIL_SHUTDOWN = (mode_ff == SVS_FAULT);
    assign FAULT_STATE = (mode_ff == SVS_FAULT);
    assign RESET_OUT_N_O = 1'b0;
    assign RESET_OUT_N_OE = reset_drive_ff;
    assign HARD_RESET_REQ = hard_req_ff;
    assign REF_WARN_IRQ = warn_irq_ff;
    assign IO_SUPPLY_STG_EVT = io_stg_ff;
    assign RAIL_OV_EVT = ov_evt_ff;
    assign RAIL_UV_EVT = uv_evt_ff;
    assign RAIL_STG_EVT = stg_evt_ff;
    assign FLAGS = flags_ff;
endmodule

// file: test/svs_supervisor_properties.sv
// Concurrent checks on the supervisor ports.
// Assumes the single clock domain and the asynchronous active-high reset.
`timescale 1ns/1ps
module svs_supervisor_checker
    import svs_pkg::*;
#(
    parameter int unsigned IO_STG_CYCLES = IO_STG_CYC,
    parameter int unsigned RAIL_STG_CYCLES = RAIL_STG_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Comparators and requests
    input wire logic IO_SUPPLY_OV,
    input wire logic IO_SUPPLY_UV,
    input wire logic BATTERY_UV,
    input wire logic [svs_pkg::NUM_RAILS-1:0] RAIL_OV,
    input wire logic [svs_pkg::NUM_RAILS-1:0] RAIL_UV,
    input wire logic [1:0] REF_WARN_CAUSE,
    input wire logic [1:0] REF_FAULT_CAUSE,
    input wire logic [svs_pkg::NUM_RAILS-1:0] RAIL_EN_REQ,
    // Outputs watched
    input wire logic [svs_pkg::NUM_EXT-1:0] EXT_RAIL_EN,
    input wire logic RAIL_SHUTDOWN,
    input wire logic RESET_OUT_N_OE,
    input wire logic HARD_RESET_REQ,
    input wire logic FAULT_STATE,
    input wire logic REF_WARN_IRQ,
    input wire logic IO_SUPPLY_STG_EVT,
    input wire logic [svs_pkg::NUM_RAILS-1:0] RAIL_OV_EVT,
    input wire logic [svs_pkg::NUM_RAILS-1:0] RAIL_UV_EVT,
    input wire logic [svs_pkg::NUM_RAILS-1:0] RAIL_STG_EVT,
    input wire logic [svs_pkg::FLAG_W-1:0] FLAGS
);
    localparam int DEG = DEG_CYC;
    localparam int UV_MIN = (IO_STG_CYCLES < DEG) ? IO_STG_CYCLES : DEG;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    ////////////////////////////////////////////////////////////////////////
    // Raw level run lengths
    function automatic logic [STG_W-1:0] step(logic [STG_W-1:0] c, logic on);
        return !on ? '0 : ((c == '1) ? c : c + 1'b1);
    endfunction

    logic [STG_W-1:0] io_ov_cnt_ff, io_uv_cnt_ff, io_ok_cnt_ff;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            io_ov_cnt_ff <= '0;
            io_uv_cnt_ff <= '0;
            io_ok_cnt_ff <= '0;
        end else begin
            io_ov_cnt_ff <= step(io_ov_cnt_ff, IO_SUPPLY_OV);
            io_uv_cnt_ff <= step(io_uv_cnt_ff, IO_SUPPLY_UV);
            io_ok_cnt_ff <= step(io_ok_cnt_ff, !IO_SUPPLY_OV && !IO_SUPPLY_UV);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Io supply and reset pin
    chk_io_reset_low: assert property ((io_ov_cnt_ff >= DEG + 3) |-> RESET_OUT_N_OE)
        else $error("reset not driven");
    chk_io_deglitch: assert property ($rose(RESET_OUT_N_OE) |-> (io_ov_cnt_ff >= DEG || io_uv_cnt_ff >= UV_MIN))
        else $error("reset too early");
    chk_io_release: assert property ((io_ok_cnt_ff >= 20'h00005) |-> !RESET_OUT_N_OE)
        else $error("reset not released");
    chk_io_stg_early: assert property ($rose(IO_SUPPLY_STG_EVT) |-> io_uv_cnt_ff >= IO_STG_CYCLES)
        else $error("io short early");
    chk_io_stg_late: assert property ((io_uv_cnt_ff >= IO_STG_CYCLES + 4) |-> IO_SUPPLY_STG_EVT)
        else $error("io short missing");
    chk_hard_reset_pulse: assert property (HARD_RESET_REQ |-> IO_SUPPLY_STG_EVT && FLAGS[FLAG_IO_SUPPLY_LOW] ##1 !HARD_RESET_REQ)
        else $error("bad hard reset");
    chk_battery_flag: assert property (BATTERY_UV [*3] |=> FLAGS[FLAG_BATTERY_LOW])
        else $error("no battery flag");

    ////////////////////////////////////////////////////////////////////////
    // Rails
    for (genvar i = 0; i < NUM_RAILS; i++) begin : g_rail
        logic [STG_W-1:0] ov_cnt_ff, uv_cnt_ff;
        always_ff @(posedge CLK or posedge RESET) begin
            if (RESET) begin
                ov_cnt_ff <= '0;
                uv_cnt_ff <= '0;
            end else begin
                ov_cnt_ff <= step(ov_cnt_ff, RAIL_OV[i]);
                uv_cnt_ff <= step(uv_cnt_ff, RAIL_UV[i]);
            end
        end
        chk_rail_ov_deglitch: assert property ($rose(RAIL_OV_EVT[i]) |-> ov_cnt_ff >= DEG)
            else $error("rail ov early");
        chk_rail_off_quiet: assert property ((!RAIL_EN_REQ[i]) [*3] |-> !(RAIL_OV_EVT[i] || RAIL_UV_EVT[i] || RAIL_STG_EVT[i]))
            else $error("disabled rail event");
        if (i >= 2) begin : g_stg
            chk_rail_stg_time: assert property ($rose(RAIL_STG_EVT[i]) |-> uv_cnt_ff >= RAIL_STG_CYCLES)
                else $error("rail short early");
        end
        if (i >= 3) begin : g_ext
            chk_ext_rail_trip: assert property ((RAIL_OV_EVT[i] || RAIL_STG_EVT[i]) |-> !EXT_RAIL_EN[i-3])
                else $error("ext rail not off");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference difference
    for (genvar j = 0; j < 2; j++) begin : g_ref
        chk_ref_warn_irq: assert property ($rose(REF_WARN_CAUSE[j]) |-> ##3 (REF_WARN_IRQ && FLAGS[FLAG_REF_WARNING_ONE+j]))
            else $error("no warning");
    end
    chk_fault_entry: assert property ($rose(|REF_FAULT_CAUSE) |-> ##3 (FAULT_STATE && RAIL_SHUTDOWN && EXT_RAIL_EN == 2'h0))
        else $error("no fault state");
    chk_fault_sticky: assert property (FAULT_STATE |=> FAULT_STATE)
        else $error("fault left");

    cover property (HARD_RESET_REQ);
    cover property ($rose(FAULT_STATE));
    cover property (REF_WARN_IRQ);
    cover property ($fell(EXT_RAIL_EN[0]));
endmodule

bind svs_supervisor svs_supervisor_checker #(.IO_STG_CYCLES(IO_STG_CYCLES), .RAIL_STG_CYCLES(RAIL_STG_CYCLES)) chk_u (.*);

// file: test/svs_mcu_model.sv
// Reset pin at the microcontroller: pull-up.
// Assumes the pin is driven only by the supervisor.
`timescale 1ns/1ps
module svs_mcu_model (
    // Reset pin drive
    input wire logic drive_o,
    input wire logic drive_oe,
    // Level seen by the microcontroller
    output logic pin_level
);
    assign pin_level = drive_oe ? drive_o : 1'b1;
endmodule

// file: test/svs_supervisor_tb.sv
// Self-checking bench for the supervisor.
// Assumes shortened short-to-ground counts; deglitch stays at full length.
`timescale 1ns/1ps
module svs_supervisor_tb;
    import svs_pkg::*;
    localparam int IO_STG = 40;
    localparam int RAIL_STG = 30;
    localparam int I_OV = 3;
    localparam int I_UV = 8;
    localparam int I_DUV = 13;
    localparam int I_WRN = 15;
    localparam int I_FLT = 17;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [18:0] cmp = '0;
    logic [NUM_RAILS-1:0] en_req = '0;
    logic [FLAG_W-1:0] flags_clr = '0;
    logic [NUM_EXT-1:0] ext_en;
    logic [NUM_RAILS-1:0] ov_evt, uv_evt, stg_evt;
    logic [FLAG_W-1:0] flags;
    logic rail_shdn, rst_o, rst_oe, hard_req, fault, irq, io_stg, pin;
    int err_total = 0, n_compared = 0, cyc = 0, hr_cnt = 0, irq_cnt = 0, n, i;

    always #2.5 clk = ~clk;

    svs_supervisor #(.IO_STG_CYCLES(IO_STG), .RAIL_STG_CYCLES(RAIL_STG)) dut_u (
        .CLK(clk), .RESET(reset), .IO_SUPPLY_OV(cmp[0]), .IO_SUPPLY_UV(cmp[1]), .BATTERY_UV(cmp[2]),
        .RAIL_OV(cmp[7:3]), .RAIL_UV(cmp[12:8]), .BUCK_DEEP_UV(cmp[14:13]), .REF_WARN_CAUSE(cmp[16:15]),
        .REF_FAULT_CAUSE(cmp[18:17]), .RAIL_EN_REQ(en_req), .EXT_RAIL_EN(ext_en), .RAIL_SHUTDOWN(rail_shdn),
        .RESET_OUT_N_O(rst_o), .RESET_OUT_N_OE(rst_oe), .HARD_RESET_REQ(hard_req), .FAULT_STATE(fault),
        .REF_WARN_IRQ(irq), .IO_SUPPLY_STG_EVT(io_stg), .RAIL_OV_EVT(ov_evt), .RAIL_UV_EVT(uv_evt),
        .RAIL_STG_EVT(stg_evt), .FLAGS_CLR(flags_clr), .FLAGS(flags));

    svs_mcu_model mcu_u (.drive_o(rst_o), .drive_oe(rst_oe), .pin_level(pin));

    ////////////////////////////////////////////////////////////////////////
    // Pulse counters and hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (hard_req === 1'b1) hr_cnt++;
        if (irq === 1'b1) irq_cnt++;
        if (cyc == 60000) begin
            err_total++;
            stop_test();
        end
    end

    function automatic bit fires(input int len, input int lim);
        return len >= lim + 3;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic run(input int idx, input int len);
        @(posedge clk) cmp[idx] <= 1'b1;
        repeat (len) @(posedge clk);
        #1;
    endtask

    task automatic drop(input int idx);
        @(posedge clk) cmp[idx] <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic reen(input int r);
        @(posedge clk) en_req[r] <= 1'b0;
        repeat (2) @(posedge clk);
        en_req[r] <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic clr();
        @(posedge clk) flags_clr <= '1;
        @(posedge clk) flags_clr <= '0;
        @(posedge clk) #1;
        chk(flags, 21'h000000);
    endtask

    task automatic do_reset();
        @(posedge clk) reset <= 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic stop_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(66184));
        do_reset();
        chk(pin, 1'b1);
        chk(flags, 21'h000000);
        // Io supply
        n = $urandom_range(100, 1500);
        run(0, n);
        chk(pin, !fires(n, DEG_CYC));
        drop(0);
        run(0, 1700);
        chk(pin, !fires(1700, DEG_CYC));
        drop(0);
        chk(pin, 1'b1);
        hr_cnt = 0;
        run(1, 20);
        drop(1);
        run(1, 20);
        chk(io_stg, 1'b0);
        drop(1);
        run(1, 50);
        chk(io_stg, fires(50, IO_STG));
        chk(flags[FLAG_IO_SUPPLY_LOW], 1'b1);
        drop(1);
        chk(hr_cnt, 1);
        run(2, 4);
        chk(flags[FLAG_BATTERY_LOW], 1'b1);
        drop(2);
        clr();
        // Rails
        @(posedge clk) en_req <= 5'h1F;
        repeat (3) @(posedge clk);
        for (i = 0; i < NUM_RAILS; i++) begin
            n = $urandom_range(100, 1500);
            run(I_OV + i, n);
            if (i < 3) chk(ov_evt[i], 1'b0);
            else chk(ext_en[i-3], 1'b1);
            drop(I_OV + i);
            run(I_OV + i, 1700);
            if (i < 3) chk({ov_evt[i], flags[FLAG_RAIL_OV_LSB+i]}, 2'h3);
            else chk(ext_en[i-3], !fires(1700, DEG_CYC));
            drop(I_OV + i);
            if (i >= 3) reen(i);
            n = (i < 3) ? 1700 : 40;
            run(I_UV + i, n);
            if (i < 3) chk({uv_evt[i], stg_evt[i]}, 2'h3);
            else chk(ext_en[i-3], !fires(n, RAIL_STG));
            drop(I_UV + i);
            if (i >= 3) reen(i);
        end
        run(I_UV + 2, 20);
        drop(I_UV + 2);
        run(I_UV + 2, 20);
        chk(stg_evt[2], 1'b0);
        drop(I_UV + 2);
        for (i = 0; i < 2; i++) begin
            run(I_DUV + i, 500);
            chk(stg_evt[i], 1'b0);
            drop(I_DUV + i);
            run(I_DUV + i, 1700);
            chk(stg_evt[i], 1'b1);
            drop(I_DUV + i);
        end
        @(posedge clk) en_req[0] <= 1'b0;
        run(I_UV, 1700);
        chk({ov_evt[0], uv_evt[0], stg_evt[0]}, 3'h0);
        drop(I_UV);
        @(posedge clk) en_req[0] <= 1'b1;
        clr();
        // References
        for (i = 0; i < 2; i++) begin
            irq_cnt = 0;
            run(I_WRN + i, 6);
            chk({irq_cnt[1:0], flags[FLAG_REF_WARNING_ONE+i]}, 3'h3);
            drop(I_WRN + i);
        end
        run(I_FLT + 1, 6);
        chk({fault, rail_shdn, ext_en, flags[FLAG_REF_FAULT_TWO]}, 5'h19);
        drop(I_FLT + 1);
        chk(fault, 1'b1);
        do_reset();
        run(I_FLT, 6);
        chk({fault, flags[FLAG_REF_FAULT_ONE]}, 2'h3);
        stop_test();
    end
endmodule
